// [hw/mic_bias_current_detect_ctrl.sv]
// Mic bias control and current detect registers with AXI4-Lite slave and interrupt
//
// How it works
// - The bias output is on only while bias enable, bit 0 of index 0x06, is set; reset 0.
// - Level bits 2:0 of index 0x07 decode to five ratios, codes 4 to 7 giving the top one.
// - Sensing for both thresholds runs only while bit 1 of index 0x06 is set; reset 0.
// - The insertion threshold is bits 6:4 of index 0x06, reset 000, ascending codes.
// - The hook threshold is a 2-bit field at bits 3:2 of index 0x06, reset 00, ascending codes.
// - While sensing, each filtered status change in the direction its polarity bit selects raises that path's own interrupt event.
// - Current above the insertion threshold means inserted, above the hook one pressed.
// - Both filtered statuses are offered as outputs for routing to a general-purpose pin.
// - Both paths are filtered so short current spikes give no false indication.
// - A hook change is signalled only after ten consecutive agreeing samples.
// - Polarity 0 flags the insertion event on insertion, polarity 1 on removal.
// - A change that happens while detector clocking is absent is reported once it returns.
module mic_bias_current_detect_ctrl
	import mic_det_pkg::*;
(
	input  wire logic              clk_sys,
	input  wire logic              rst,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              ins_cmp_in,
	input  wire logic              hook_cmp_in,
	input  wire logic              det_clk_ok_in,
	output logic                   bias_output,
	output logic [2:0]             bias_ratio_sel,
	output logic                   current_sense_enable,
	output logic [2:0]             insertion_current_threshold,
	output logic [1:0]             hook_current_threshold,
	output logic                   gpio_ins_status,
	output logic                   gpio_hook_status,
	output logic                   irq
);

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
	                                        input logic [3:0] strb, input logic [15:0] msk);
		logic [15:0] r;
		r = old;
		if (strb[0])
			r[7:0] = wd[7:0];
		if (strb[1])
			r[15:8] = wd[15:8];
		return r & msk;
	endfunction : merge16

	function automatic logic [5:0] reg_index(input logic [ADDR_W-1:0] a);
		return a[ADDR_W-1:2];
	endfunction : reg_index

	function automatic logic is_mapped(input logic [5:0] i);
		return i == IDX_BIAS_CTRL || i == IDX_BIAS_LEVEL || i == IDX_IRQ_STAT
		    || i == IDX_IRQ_MASK || i == IDX_DET_CFG;
	endfunction : is_mapped

	// Pin synchronisers
	det_pins_s                   pin_s1_ff;
	det_pins_s                   pin_s2_ff;
	det_pins_s                   pin_s3_ff;
	det_pins_s                   pin_ff;
	det_pins_s                   nxt_pin;
	det_pins_s                   raw_pins;

	bias_ctrl_s                  ctrl_ff;
	logic [15:0]                 level_ff;
	logic [1:0]                  stat_ff;
	logic [1:0]                  mask_ff;
	logic [1:0]                  pol_ff;
	logic [2:0]                  ratio_ff;
	logic                        irq_ff;
	logic [SAMPLE_CNT_W-1:0]     tick_cnt_ff;
	logic                        tick_ff;

	logic                        aw_hold_ff;
	logic                        w_hold_ff;
	logic [ADDR_W-1:0]           awaddr_ff;
	logic [31:0]                 wdata_ff;
	logic [3:0]                  wstrb_ff;
	logic                        bvalid_ff;
	logic [1:0]                  bresp_ff;
	logic                        rvalid_ff;
	logic [31:0]                 rdata_ff;
	logic [1:0]                  rresp_ff;

	logic                        ins_state;
	logic                        ins_changed;
	logic                        hook_state;
	logic                        hook_changed;

	assign raw_pins = '{clk_ok: det_clk_ok_in, hook: hook_cmp_in, ins: ins_cmp_in};

	// Only bits where the second and third stages agree are taken
	assign nxt_pin = (pin_s2_ff & ~(pin_s2_ff ^ pin_s3_ff)) | (pin_ff & (pin_s2_ff ^ pin_s3_ff));

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			pin_s1_ff <= '0;
			pin_s2_ff <= '0;
			pin_s3_ff <= '0;
			pin_ff    <= '0;
		end
		else
		begin
			pin_s1_ff <= raw_pins;
			pin_s2_ff <= pin_s1_ff;
			pin_s3_ff <= pin_s2_ff;
			pin_ff    <= nxt_pin;
		end
	end

	// Measurement ticks stop while clocking is absent, freezing the filters so that a
	// change made meanwhile is still seen once ticks resume
	wire sense_on = ctrl_ff.sense_en;
	wire tick_run = sense_on && pin_ff.clk_ok;
	wire [SAMPLE_CNT_W-1:0] nxt_tick_cnt = !tick_run ? '0
	                                    : (tick_cnt_ff == SAMPLE_LAST) ? '0 : tick_cnt_ff + 1'b1;
	wire nxt_tick = tick_run && (tick_cnt_ff == SAMPLE_LAST);

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			tick_cnt_ff <= '0;
			tick_ff     <= 1'b0;
		end
		else
		begin
			tick_cnt_ff <= nxt_tick_cnt;
			tick_ff     <= nxt_tick;
		end
	end

	// Comparator high means current above the threshold
	mic_cur_filter #(.SAMPLES(INS_SAMPLES)) u_ins_filter
	(
		.clk_sys    (clk_sys),
		.rst        (rst),
		.enable     (sense_on),
		.sample     (tick_ff),
		.level_in   (pin_ff.ins),
		.state_ff   (ins_state),
		.changed_ff (ins_changed)
	);

	// Hook path flips only after ten agreeing samples in a row
	mic_cur_filter #(.SAMPLES(HOOK_SAMPLES)) u_hook_filter
	(
		.clk_sys    (clk_sys),
		.rst        (rst),
		.enable     (sense_on),
		.sample     (tick_ff),
		.level_in   (pin_ff.hook),
		.state_ff   (hook_state),
		.changed_ff (hook_changed)
	);

	// Polarity picks the edge of each filtered state that raises its event
	wire ins_event  = ins_changed && (ins_state != pol_ff[EV_INS_BIT]);
	wire hook_event = hook_changed && (hook_state != pol_ff[EV_HOOK_BIT]);
	wire [1:0] hw_set;
	assign hw_set[EV_INS_BIT]  = ins_event;
	assign hw_set[EV_HOOK_BIT] = hook_event;

	// AXI4-Lite write side: address and data taken in either order
	assign s_axi_awready = !aw_hold_ff && !bvalid_ff;
	assign s_axi_wready  = !w_hold_ff && !bvalid_ff;
	wire aw_take  = s_axi_awvalid && s_axi_awready;
	wire w_take   = s_axi_wvalid && s_axi_wready;
	wire do_write = aw_hold_ff && w_hold_ff && !bvalid_ff;
	wire [5:0] wr_idx = reg_index(awaddr_ff);
	wire wr_ctrl  = do_write && wr_idx == IDX_BIAS_CTRL;
	wire wr_level = do_write && wr_idx == IDX_BIAS_LEVEL;
	wire wr_stat  = do_write && wr_idx == IDX_IRQ_STAT;
	wire wr_mask  = do_write && wr_idx == IDX_IRQ_MASK;
	wire wr_cfg   = do_write && wr_idx == IDX_DET_CFG;
	wire [1:0] w1c = wr_stat && wstrb_ff[0] ? wdata_ff[1:0] : 2'h0;

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			aw_hold_ff <= 1'b0;
			w_hold_ff  <= 1'b0;
			awaddr_ff  <= '0;
			wdata_ff   <= '0;
			wstrb_ff   <= '0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= RESP_OKAY;
		end
		else
		begin
			if (aw_take)
			begin
				aw_hold_ff <= 1'b1;
				awaddr_ff  <= s_axi_awaddr;
			end
			if (w_take)
			begin
				w_hold_ff <= 1'b1;
				wdata_ff  <= s_axi_wdata;
				wstrb_ff  <= s_axi_wstrb;
			end
			if (do_write)
			begin
				aw_hold_ff <= 1'b0;
				w_hold_ff  <= 1'b0;
				bvalid_ff  <= 1'b1;
				bresp_ff   <= is_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_bready)
				bvalid_ff <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp  = bresp_ff;

	// Register file; hardware set wins over a simultaneous write-one clear
	wire [15:0] nxt_ctrl  = wr_ctrl ? merge16(ctrl_ff, wdata_ff, wstrb_ff, BIAS_CTRL_MASK)
	                      : ctrl_ff;
	wire [15:0] nxt_level = wr_level ? merge16(level_ff, wdata_ff, wstrb_ff, BIAS_LEVEL_MASK)
	                      : level_ff;
	wire [15:0] mask_wr   = merge16({14'h0, mask_ff}, wdata_ff, wstrb_ff, DET_CFG_MASK);
	wire [15:0] cfg_wr    = merge16({14'h0, pol_ff}, wdata_ff, wstrb_ff, DET_CFG_MASK);
	wire [1:0]  nxt_stat  = (stat_ff & ~w1c) | hw_set;
	wire        nxt_irq   = |(nxt_stat & mask_ff);

	// Level codes above the top step saturate to it
	wire [2:0] nxt_ratio = (level_ff[2:0] > LEVEL_TOP) ? LEVEL_TOP : level_ff[2:0];

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			ctrl_ff  <= BIAS_CTRL_RST;
			level_ff <= BIAS_LEVEL_RST;
			stat_ff  <= EV_RST;
			mask_ff  <= EV_RST;
			pol_ff   <= EV_RST;
			ratio_ff <= 3'h0;
			irq_ff   <= 1'b0;
		end
		else
		begin
			ctrl_ff  <= nxt_ctrl;
			level_ff <= nxt_level;
			stat_ff  <= nxt_stat;
			mask_ff  <= wr_mask ? mask_wr[1:0] : mask_ff;
			pol_ff   <= wr_cfg ? cfg_wr[1:0] : pol_ff;
			ratio_ff <= nxt_ratio;
			irq_ff   <= nxt_irq;
		end
	end

	// AXI4-Lite read side, one cycle from address to data
	assign s_axi_arready = !rvalid_ff;
	wire ar_take = s_axi_arvalid && s_axi_arready;
	wire [5:0] rd_idx = reg_index(s_axi_araddr);
	wire [15:0] cfg_rd = {6'h0, hook_state, ins_state, 6'h0, pol_ff};
	wire [15:0] rd_word = rd_idx == IDX_BIAS_CTRL  ? ctrl_ff
	                    : rd_idx == IDX_BIAS_LEVEL ? level_ff
	                    : rd_idx == IDX_IRQ_STAT   ? {14'h0, stat_ff}
	                    : rd_idx == IDX_IRQ_MASK   ? {14'h0, mask_ff}
	                    : rd_idx == IDX_DET_CFG    ? cfg_rd : 16'h0000;

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= '0;
			rresp_ff  <= RESP_OKAY;
		end
		else if (ar_take)
		begin
			rvalid_ff <= 1'b1;
			rdata_ff  <= {16'h0000, rd_word};
			rresp_ff  <= is_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_rready)
			rvalid_ff <= 1'b0;
	end

	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata  = rdata_ff;
	assign s_axi_rresp  = rresp_ff;

	assign bias_output                 = ctrl_ff.bias_en;
	assign bias_ratio_sel              = ratio_ff;
	assign current_sense_enable        = ctrl_ff.sense_en;
	assign insertion_current_threshold = ctrl_ff.ins_thr;
	assign hook_current_threshold      = ctrl_ff.hook_thr;
	assign gpio_ins_status             = ins_state;
	assign gpio_hook_status            = hook_state;
	assign irq                         = irq_ff;

	a_bias_enable: assert property (@(posedge clk_sys) disable iff (rst)
		(wr_ctrl && wstrb_ff[0]) |=> bias_output == $past(wdata_ff[BIAS_EN_BIT]))
		else $error("bias output does not follow its enable write");

	a_level_saturate: assert property (@(posedge clk_sys) disable iff (rst)
		level_ff[2] |=> bias_ratio_sel == LEVEL_TOP)
		else $error("high level code did not select the top ratio");

	a_sense_off_quiet: assert property (@(posedge clk_sys) disable iff (rst)
		!current_sense_enable |=> !gpio_ins_status && !gpio_hook_status && !tick_ff)
		else $error("detect activity while sensing is disabled");

	a_ins_thr_hold: assert property (@(posedge clk_sys) disable iff (rst)
		!wr_ctrl |=> $stable(insertion_current_threshold))
		else $error("insertion threshold changed without a write");

	a_hook_thr_write: assert property (@(posedge clk_sys) disable iff (rst)
		(wr_ctrl && wstrb_ff[0]) |=> hook_current_threshold == $past(wdata_ff[3:2]))
		else $error("hook threshold does not follow its write");

	a_ins_event_flag: assert property (@(posedge clk_sys) disable iff (rst)
		(ins_changed && ins_state == !pol_ff[EV_INS_BIT]) |=> stat_ff[EV_INS_BIT])
		else $error("insertion event did not set its flag");

	a_hook_event_irq: assert property (@(posedge clk_sys) disable iff (rst)
		(hook_event && mask_ff[EV_HOOK_BIT] && !wr_mask) |=> irq)
		else $error("unmasked hook event did not raise the interrupt");

	a_ticks_need_clock: assert property (@(posedge clk_sys) disable iff (rst)
		!pin_ff.clk_ok |=> !tick_ff)
		else $error("sample tick while detector clocking is absent");

	a_sync_agree: assert property (@(posedge clk_sys) disable iff (rst)
		(pin_s2_ff.ins != pin_s3_ff.ins) |=> $stable(pin_ff.ins))
		else $error("synchronised input moved before stages agreed");

endmodule : mic_bias_current_detect_ctrl

// [hw/mic_det_pkg.sv]
// Shared constants and carriers for the mic bias and current detect control block
package mic_det_pkg;

	// Register indices; byte address is four times the index
	localparam logic [5:0] IDX_BIAS_CTRL  = 6'h06;
	localparam logic [5:0] IDX_BIAS_LEVEL = 6'h07;
	localparam logic [5:0] IDX_IRQ_STAT   = 6'h08;
	localparam logic [5:0] IDX_IRQ_MASK   = 6'h09;
	localparam logic [5:0] IDX_DET_CFG    = 6'h0A;

	localparam int ADDR_W = 8;

	// Bias control word layout
	localparam int BIAS_EN_BIT   = 0;
	localparam int SENSE_EN_BIT  = 1;
	localparam int HOOK_THR_LSB  = 2;
	localparam int INS_THR_LSB   = 4;
	localparam logic [15:0] BIAS_CTRL_RST  = 16'h0000;
	localparam logic [15:0] BIAS_CTRL_MASK = 16'h007F;
	localparam logic [15:0] BIAS_LEVEL_RST  = 16'h0000;
	localparam logic [15:0] BIAS_LEVEL_MASK = 16'h0007;

	// Interrupt status / mask layout, and detect config layout
	localparam int EV_INS_BIT  = 0;
	localparam int EV_HOOK_BIT = 1;
	localparam logic [1:0] EV_RST = 2'h0;
	localparam logic [15:0] DET_CFG_MASK = 16'h0003;
	localparam int CFG_INS_LIVE_BIT  = 8;
	localparam int CFG_HOOK_LIVE_BIT = 9;

	// Highest level code that is a distinct step; codes above saturate
	localparam logic [2:0] LEVEL_TOP = 3'h4;

	// Timing
	localparam int CLK_PERIOD_NS    = 5;
	localparam int SAMPLE_PERIOD_NS = 4000;
	localparam int SAMPLE_CYC = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
	localparam int HOOK_SAMPLES = 10;
	localparam int INS_SAMPLES  = 3;
	localparam int SAMPLE_CNT_W = 10;
	localparam logic [SAMPLE_CNT_W-1:0] SAMPLE_LAST = SAMPLE_CNT_W'(SAMPLE_CYC - 1);

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed
	{
		logic [8:0] rsvd;
		logic [2:0] ins_thr;
		logic [1:0] hook_thr;
		logic       sense_en;
		logic       bias_en;
	} bias_ctrl_s;

	// Synchronised pin group: clocking ok, hook comparator, insertion comparator
	typedef struct packed
	{
		logic clk_ok;
		logic hook;
		logic ins;
	} det_pins_s;

endpackage : mic_det_pkg

// [hw/mic_cur_filter.sv]
// Sample-count filter for one current detect comparator path
module mic_cur_filter
	import mic_det_pkg::*;
#(
	parameter int SAMPLES = 10
)
(
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic enable,
	input  wire logic sample,
	input  wire logic level_in,
	output logic      state_ff,
	output logic      changed_ff
);
	localparam logic [3:0] CNT_LAST = 4'(SAMPLES - 1);

	logic [3:0] cnt_ff;
	logic [3:0] nxt_cnt;
	logic       nxt_state;
	logic       nxt_changed;
	wire        differs = level_in != state_ff;
	wire        flip    = sample && differs && (cnt_ff == CNT_LAST);

	// A spike shorter than the full run of samples restarts the count
	assign nxt_cnt     = !enable ? 4'h0 : !sample ? cnt_ff : (!differs || flip) ? 4'h0
	                   : cnt_ff + 4'h1;
	assign nxt_state   = !enable ? 1'b0 : (flip ? level_in : state_ff);
	assign nxt_changed = enable && flip;

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			cnt_ff     <= 4'h0;
			state_ff   <= 1'b0;
			changed_ff <= 1'b0;
		end
		else
		begin
			cnt_ff     <= nxt_cnt;
			state_ff   <= nxt_state;
			changed_ff <= nxt_changed;
		end
	end

	a_run_length: assert property (@(posedge clk_sys) disable iff (rst)
		changed_ff |-> $past(cnt_ff) == CNT_LAST && $past(sample))
		else $error("state changed without a full run of samples");

	a_spike_rejected: assert property (@(posedge clk_sys) disable iff (rst)
		(enable && sample && !differs) |=> cnt_ff == 4'h0 && !changed_ff)
		else $error("matching sample did not restart the run");

endmodule : mic_cur_filter

// [sim/mic_cur_model.sv]
// Behavioural bias current comparators standing in for the analog detect front end
module mic_cur_model
(
	input  wire logic        bias_on,
	input  wire logic        sense_on,
	input  wire logic [2:0]  ins_code,
	input  wire logic [1:0]  hook_code,
	input  wire logic [31:0] current_ua,
	output logic             ins_cmp,
	output logic             hook_cmp
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] ins_ua;
	logic [31:0] hook_ua;
	// Thresholds in microamps; both rise with the code
	assign ins_ua   = 32'h46 + 32'hBE * 32'(ins_code);
	assign hook_ua  = 32'h208 + 32'h168 * 32'(hook_code);
	// Without bias or sensing nothing is measured, so both comparators read low
	assign ins_cmp  = bias_on && sense_on && (current_ua > ins_ua);
	assign hook_cmp = bias_on && sense_on && (current_ua > hook_ua);
endmodule : mic_cur_model

// [sim/tb_mic_bias_current_detect_ctrl.sv]
// Self-checking bench for the mic bias control and current detect block
module tb_mic_bias_current_detect_ctrl
	import mic_det_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] A_CTRL  = {IDX_BIAS_CTRL, 2'h0};
	localparam logic [7:0] A_LEVEL = {IDX_BIAS_LEVEL, 2'h0};
	localparam logic [7:0] A_STAT  = {IDX_IRQ_STAT, 2'h0};
	localparam logic [7:0] A_MASK  = {IDX_IRQ_MASK, 2'h0};
	localparam logic [7:0] A_CFG   = {IDX_DET_CFG, 2'h0};
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, det_clk_ok_in = 1'b1;
	logic [31:0] s_axi_wdata = '0, cur = '0, rd_data;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, hook_current_threshold;
	logic [31:0] s_axi_rdata;
	logic ins_cmp_in, hook_cmp_in, bias_output, current_sense_enable;
	logic [2:0] bias_ratio_sel, insertion_current_threshold, ic;
	logic gpio_ins_status, gpio_hook_status, irq;
	logic [15:0] v;
	int mismatches = 0, cmp_count = 0, cyc = 0;

	always #2.5 clk_sys = ~clk_sys;

	mic_bias_current_detect_ctrl dut_u (.clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ins_cmp_in, .hook_cmp_in,
		.det_clk_ok_in, .bias_output, .bias_ratio_sel, .current_sense_enable,
		.insertion_current_threshold, .hook_current_threshold, .gpio_ins_status,
		.gpio_hook_status, .irq);

	mic_cur_model model_u (.bias_on(bias_output), .sense_on(current_sense_enable),
		.ins_code(insertion_current_threshold), .hook_code(hook_current_threshold),
		.current_ua(cur), .ins_cmp(ins_cmp_in), .hook_cmp(hook_cmp_in));

	function automatic logic [2:0] ratio_of(input logic [2:0] c);
		return (c > LEVEL_TOP) ? LEVEL_TOP : c;
	endfunction : ratio_of

	function automatic logic [31:0] ins_ua(input logic [2:0] c);
		return 32'h46 + 32'hBE * 32'(c);
	endfunction : ins_ua

	task automatic test_done();
		$display("checks %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : test_done

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			mismatches++;
		end
	endtask : chk

	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : idle

	task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
		logic aw, w, ha, hw, hb;
		logic [1:0] r;
		// Let an edge pass so a back-to-back call never reassigns bready in one step
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		aw = 1'b1;
		w = 1'b1;
		hb = 1'b0;
		// Decide at the falling edge, act just after the rising edge that takes it
		while (aw || w)
		begin
			@(negedge clk_sys);
			ha = s_axi_awvalid && s_axi_awready;
			hw = s_axi_wvalid && s_axi_wready;
			@(posedge clk_sys);
			if (ha) s_axi_awvalid <= 1'b0;
			if (hw) s_axi_wvalid <= 1'b0;
			aw = aw && !ha;
			w = w && !hw;
		end
		while (!hb)
		begin
			@(negedge clk_sys);
			hb = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge clk_sys);
		end
		s_axi_bready <= 1'b0;
		chk(32'(r), 32'(er));
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic ha, hr;
		logic [1:0] r;
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		ha = 1'b0;
		hr = 1'b0;
		while (!ha)
		begin
			@(negedge clk_sys);
			ha = s_axi_arready;
			@(posedge clk_sys);
		end
		s_axi_arvalid <= 1'b0;
		while (!hr)
		begin
			@(negedge clk_sys);
			hr = s_axi_rvalid;
			rd_data = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge clk_sys);
		end
		s_axi_rready <= 1'b0;
		chk(rd_data, ed);
		chk(32'(r), 32'(er));
	endtask : rd

	task automatic wait_st(input logic ins, input logic val, input int lim);
		int n;
		logic s;
		n = 0;
		s = !val;
		while (s !== val && n < lim)
		begin
			@(negedge clk_sys);
			s = ins ? gpio_ins_status : gpio_hook_status;
			n++;
		end
		@(posedge clk_sys);
		chk(32'(s), 32'(val));
	endtask : wait_st

	always @(posedge clk_sys)
	begin
		cyc <= cyc + 1;
		// Whole run needs about 28k cycles
		if (cyc == 60000)
		begin
			mismatches++;
			test_done();
		end
	end

	initial
	begin
		void'($urandom(6));
		idle(6);
		rst <= 1'b0;
		@(posedge clk_sys);
		rd(A_CTRL, 32'h0, RESP_OKAY);
		rd(A_LEVEL, 32'h0, RESP_OKAY);
		rd(A_STAT, 32'h0, RESP_OKAY);
		chk(32'({bias_output, current_sense_enable, irq}), 32'h0);
		rd(8'h2C, 32'h0, RESP_SLVERR);
		wr(8'h2C, 16'hFFFF, RESP_SLVERR);
		$display("test reset_and_map done");
		for (int c = 0; c < 8; c++)
		begin
			v = (16'($urandom) & 16'hFFF8) | 16'(c);
			wr(A_LEVEL, v, RESP_OKAY);
			// Ratio register updates on the edge the task returns at; look once it settles
			@(negedge clk_sys);
			chk(32'(bias_ratio_sel), 32'(ratio_of(3'(c))));
			rd(A_LEVEL, 32'(c), RESP_OKAY);
		end
		for (int i = 0; i < 8; i++)
		begin
			v = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : 16'($urandom);
			wr(A_CTRL, v, RESP_OKAY);
			rd(A_CTRL, 32'(v & 16'h007F), RESP_OKAY);
			chk(32'({insertion_current_threshold, hook_current_threshold,
				current_sense_enable, bias_output}), 32'(v[6:0]));
		end
		// Upper byte strobe alone must leave the control fields untouched
		s_axi_wstrb <= 4'h2;
		wr(A_CTRL, ~v, RESP_OKAY);
		s_axi_wstrb <= 4'hF;
		rd(A_CTRL, 32'(v & 16'h007F), RESP_OKAY);
		$display("test registers done");
		ic = 3'($urandom_range(2));
		wr(A_MASK, 16'h0003, RESP_OKAY);
		wr(A_CTRL, {9'h000, ic, 2'h3, 2'h3}, RESP_OKAY);
		// A spike shorter than one sample period must not flip the state
		cur <= ins_ua(ic) + 32'h32;
		idle(100);
		cur <= 32'h0;
		idle(3000);
		chk(32'(gpio_ins_status), 32'h0);
		cur <= ins_ua(ic) + 32'h32;
		wait_st(1'b1, 1'b1, 4 * SAMPLE_CYC + 20);
		idle(3);
		chk(32'({gpio_hook_status, irq}), 32'h1);
		rd(A_STAT, 32'h1, RESP_OKAY);
		wr(A_STAT, 16'h0001, RESP_OKAY);
		idle(3);
		chk(32'(irq), 32'h0);
		$display("test insertion done");
		wr(A_MASK, 16'h0001, RESP_OKAY);
		cur <= 32'h6A4;
		idle(8 * SAMPLE_CYC);
		chk(32'(gpio_hook_status), 32'h0);
		wait_st(1'b0, 1'b1, 3 * SAMPLE_CYC);
		idle(3);
		rd(A_STAT, 32'h2, RESP_OKAY);
		chk(32'(irq), 32'h0);
		wr(A_MASK, 16'h0003, RESP_OKAY);
		idle(3);
		chk(32'(irq), 32'h1);
		wr(A_STAT, 16'h0003, RESP_OKAY);
		$display("test hook done");
		// Both polarities inverted: removal and hook release each set their flag
		wr(A_CFG, 16'h0003, RESP_OKAY);
		rd(A_CFG, 32'h0303, RESP_OKAY);
		cur <= 32'h0;
		wait_st(1'b1, 1'b0, 4 * SAMPLE_CYC + 20);
		wait_st(1'b0, 1'b0, 11 * SAMPLE_CYC);
		idle(3);
		rd(A_STAT, 32'h3, RESP_OKAY);
		wr(A_STAT, 16'h0003, RESP_OKAY);
		$display("test removal done");
		wr(A_CFG, 16'h0000, RESP_OKAY);
		det_clk_ok_in <= 1'b0;
		cur <= ins_ua(ic) + 32'h32;
		idle(5 * SAMPLE_CYC);
		chk(32'(gpio_ins_status), 32'h0);
		det_clk_ok_in <= 1'b1;
		wait_st(1'b1, 1'b1, 4 * SAMPLE_CYC + 20);
		idle(3);
		rd(A_STAT, 32'h1, RESP_OKAY);
		wr(A_CTRL, {9'h000, ic, 2'h3, 2'h1}, RESP_OKAY);
		idle(8);
		chk(32'({gpio_ins_status, current_sense_enable}), 32'h0);
		$display("test clock_absent_and_disable done");
		test_done();
	end
endmodule : tb_mic_bias_current_detect_ctrl
